// ===== rtl/safety_guard_control.sv
// safety guard: ram and register write guards, parity reset, status irq
`timescale 1ns/1ps
`default_nettype none
module safety_guard_control (
  input wire logic sys_clk, // 200 MHz system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [15:0] address, // register index
  input wire logic read, // avalon read
  input wire logic write, // avalon write
  input wire logic [31:0] writedata, // avalon write data
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon wait
  input wire logic ram_wr_req, // cpu ram write strobe
  input wire logic [19:0] ram_wr_addr, // cpu ram write address
  output logic ram_wr_en, // ram write allowed, one cycle late
  output logic [19:0] ram_wr_addr_out, // registered ram address
  input wire logic sfr_wr_req, // cpu register write strobe
  input wire logic [3:0] sfr_wr_group, // guarded group index
  output logic sfr_wr_en, // register write allowed
  input wire logic ram_parity_err, // parity error on ram read
  input wire logic crc_done, // crc calculation finished
  input wire logic flash_done, // data flash erase/program done
  input wire logic unused_exec, // pc in unused program area
  input wire logic unused_rst_opt, // code option enables that reset
  input wire logic debug_mode, // on-chip debug active
  output logic safety_reset, // reset request pulse
  output logic parity_rst_status, // reset cause: parity, pulse
  output logic unused_rst_status, // reset cause: unused area, pulse
  output logic debug_break, // debug break pulse
  output logic status_irq, // status interrupt request pulse
  output logic [1:0] uart_loopback // loop-back test enables
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [2:0] ram_area;
  logic [5:0] reg_guard0;
  logic [2:0] reg_guard1;
  logic parity_reset_enable;
  logic parity_error_flag;
  logic [1:0] loopback_test;
  logic [2:0] status_irq_enable;
  logic [2:0] status_irq_flags;
  safety_guard_pkg::bus_state_type bus_state;
  logic wr_take;
  logic rd_take;
  logic [7:0] wbyte;
  logic [31:0] next_readdata;
  logic [8:0] group_guard;
  logic [19:0] area_base;
  logic ram_blocked;
  logic [2:0] flag_event;
  logic [2:0] flag_clear;
  logic [2:0] next_flags;
  logic rerequest;

  assign wr_take = write && !waitrequest;
  assign rd_take = read && waitrequest && bus_state == safety_guard_pkg::BUS_IDLE;
  assign wbyte = writedata[7:0];

  // ---------------------------------------------------------------
  // avalon slave handshake
  // ---------------------------------------------------------------
  // one wait cycle, then a single ack cycle; a write is taken in the ack cycle, a read in the wait cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= safety_guard_pkg::BUS_IDLE;
      waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        safety_guard_pkg::BUS_IDLE: begin
          if (read || write) begin
            bus_state <= safety_guard_pkg::BUS_ACK;
            waitrequest <= 1'b0;
          end
        end
        default: begin
          bus_state <= safety_guard_pkg::BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // reserved bits and write-only bytes read as zero
  always_comb begin
    next_readdata = safety_guard_pkg::READ_ZERO;
    if (address == safety_guard_pkg::IDX_IRQ_ENABLE) begin
      next_readdata[2:0] = status_irq_enable;
    end else if (address == safety_guard_pkg::IDX_IRQ_FLAGS) begin
      next_readdata[2:0] = status_irq_flags & safety_guard_pkg::EN_MASK;
    end else if (address == safety_guard_pkg::IDX_RAM_GUARD) begin
      next_readdata[2:0] = ram_area;
    end else if (address == safety_guard_pkg::IDX_GUARD0_LOW) begin
      next_readdata[5:0] = reg_guard0;
    end else if (address == safety_guard_pkg::IDX_GUARD1_LOW) begin
      next_readdata[2:0] = reg_guard1;
    end else if (address == safety_guard_pkg::IDX_PARITY_SET) begin
      next_readdata[safety_guard_pkg::BIT_PARITY_ERROR_FLAG] = parity_error_flag;
      next_readdata[safety_guard_pkg::BIT_PARITY_RESET_ENABLE] = parity_reset_enable;
    end else if (address == safety_guard_pkg::IDX_LOOP_LOW) begin
      next_readdata[1:0] = loopback_test;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= safety_guard_pkg::READ_ZERO;
    end else if (rd_take) begin
      readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_area <= safety_guard_pkg::RST_AREA;
      reg_guard0 <= safety_guard_pkg::RST_BYTE[5:0];
      reg_guard1 <= safety_guard_pkg::RST_BYTE[2:0];
      parity_reset_enable <= 1'b0;
      loopback_test <= safety_guard_pkg::RST_BYTE[1:0];
      status_irq_enable <= safety_guard_pkg::RST_BYTE[2:0];
    end else if (wr_take) begin
      if (address == safety_guard_pkg::IDX_RAM_GUARD) begin
        ram_area <= wbyte[2:0];
      end else if (address == safety_guard_pkg::IDX_GUARD0_LOW) begin
        reg_guard0 <= wbyte[5:0];
      end else if (address == safety_guard_pkg::IDX_GUARD1_LOW) begin
        reg_guard1 <= wbyte[2:0];
      end else if (address == safety_guard_pkg::IDX_PARITY_SET) begin
        parity_reset_enable <= wbyte[safety_guard_pkg::BIT_PARITY_RESET_ENABLE];
      end else if (address == safety_guard_pkg::IDX_LOOP_LOW) begin
        loopback_test <= wbyte[1:0];
      end else if (address == safety_guard_pkg::IDX_IRQ_ENABLE) begin
        status_irq_enable <= wbyte[2:0] & safety_guard_pkg::EN_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      uart_loopback <= 2'b00;
    end else begin
      uart_loopback <= loopback_test;
    end
  end

  // ---------------------------------------------------------------
  // ram write guard
  // ---------------------------------------------------------------
  always_comb begin
    if (ram_area == safety_guard_pkg::AREA_64) begin
      area_base = safety_guard_pkg::RAM_BASE_64;
    end else if (ram_area == safety_guard_pkg::AREA_128) begin
      area_base = safety_guard_pkg::RAM_BASE_128;
    end else if (ram_area == safety_guard_pkg::AREA_256) begin
      area_base = safety_guard_pkg::RAM_BASE_256;
    end else begin
      area_base = safety_guard_pkg::RAM_BASE_512;
    end
  end

  assign ram_blocked = ram_area != safety_guard_pkg::AREA_OFF &&
    ram_wr_addr >= area_base && ram_wr_addr <= safety_guard_pkg::RAM_TOP;

  // blocked writes vanish; no error and no flag
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_wr_en <= 1'b0;
      ram_wr_addr_out <= 20'h0_0000;
    end else begin
      ram_wr_en <= ram_wr_req && !ram_blocked;
      ram_wr_addr_out <= ram_wr_addr;
    end
  end

  // ---------------------------------------------------------------
  // register group guard
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < safety_guard_pkg::GROUPS; g++) begin : gen_guard
      if (g < safety_guard_pkg::GUARD0_W) begin : gen_g0
        assign group_guard[g] = reg_guard0[g];
      end else begin : gen_g1
        assign group_guard[g] = reg_guard1[g - safety_guard_pkg::GUARD0_W];
      end
    end
  endgenerate

  // reads of guarded groups are untouched; only writes are gated
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_wr_en <= 1'b0;
    end else if (sfr_wr_group < 4'(safety_guard_pkg::GROUPS)) begin
      sfr_wr_en <= sfr_wr_req && !group_guard[sfr_wr_group];
    end else begin
      sfr_wr_en <= sfr_wr_req;
    end
  end

  // ---------------------------------------------------------------
  // parity and unused-area resets
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      parity_error_flag <= 1'b0;
    end else if (ram_parity_err) begin
      parity_error_flag <= 1'b1;
    end else if (wr_take && address == safety_guard_pkg::IDX_PARITY_SET &&
                 wbyte[safety_guard_pkg::BIT_PARITY_ERROR_FLAG]) begin
      parity_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      safety_reset <= 1'b0;
      parity_rst_status <= 1'b0;
      unused_rst_status <= 1'b0;
      debug_break <= 1'b0;
    end else begin
      parity_rst_status <= ram_parity_err && parity_reset_enable &&
        !debug_mode;
      unused_rst_status <= unused_exec && unused_rst_opt &&
        !debug_mode;
      safety_reset <= (ram_parity_err && parity_reset_enable && !debug_mode) ||
        (unused_exec && unused_rst_opt && !debug_mode);
      debug_break <= ram_parity_err && debug_mode;
    end
  end

  // ---------------------------------------------------------------
  // status interrupt
  // ---------------------------------------------------------------
  assign flag_event = {flash_done, crc_done, ram_parity_err};
  assign flag_clear = (wr_take &&
    address == safety_guard_pkg::IDX_IRQ_CLEAR_LOW) ? wbyte[2:0] : 3'b000;
  // set wins over a clear in the same cycle
  assign next_flags = (status_irq_flags & ~flag_clear) | flag_event;
  assign rerequest = wr_take &&
    address == safety_guard_pkg::IDX_IRQ_CLEAR_HIGH &&
    wbyte[safety_guard_pkg::BIT_REREQ];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_irq_flags <= safety_guard_pkg::RST_BYTE[2:0];
    end else begin
      status_irq_flags <= next_flags;
    end
  end

  // a 0-to-1 change of an enabled flag or a re-request write requests; repeats are swallowed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_irq <= 1'b0;
    end else begin
      status_irq <= |(flag_event & ~status_irq_flags & status_irq_enable) ||
        (rerequest && |(status_irq_flags & status_irq_enable));
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ack_one_cycle: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $fell(waitrequest) |=> waitrequest)
    else $error("ack lasted more than one cycle");

  a_ram_guard_off: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ram_wr_req && ram_area == 3'h0 |=> ram_wr_en)
    else $error("write dropped with guard off");

  a_ram_guard_64: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ram_wr_req && ram_area == 3'h1 |->
    ##1 ram_wr_en == ($past(ram_wr_addr) < 20'h0_EFC0 ||
                      $past(ram_wr_addr) > 20'h0_EFFF))
    else $error("64-byte guard wrong");

  a_ram_guard_512: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ram_wr_req && ram_area[2] && ram_wr_addr >= 20'h0_EE00 &&
    ram_wr_addr <= 20'h0_EFFF |=> !ram_wr_en)
    else $error("512-byte guard not applied");

  a_group_guard: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    sfr_wr_req && sfr_wr_group < 4'h6 && reg_guard0[sfr_wr_group[2:0]]
    |=> !sfr_wr_en)
    else $error("guarded group written");

  a_flag_read_only: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !(|flag_event) && !(|flag_clear) |=> $stable(status_irq_flags))
    else $error("status flags changed without cause");

  a_debug_no_reset: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    debug_mode && ram_parity_err |=> debug_break && !safety_reset ##1
    !debug_break)
    else $error("parity error in debug did not break");

  a_unused_reset: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    unused_exec && unused_rst_opt && !debug_mode |=>
    safety_reset && unused_rst_status)
    else $error("unused area reset missing");

  a_no_repeat_irq: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    status_irq_flags[0] && ram_parity_err && !rerequest |=> !status_irq)
    else $error("repeat event requested again");

  a_rerequest: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rerequest && |(status_irq_flags & status_irq_enable) |=> status_irq)
    else $error("re-request not issued");

  c_guarded_drop: cover property (@(posedge sys_clk) disable iff (!rst_b)
    ram_wr_req && ram_blocked);
  c_parity_reset: cover property (@(posedge sys_clk) disable iff (!rst_b)
    safety_reset && parity_rst_status);
  c_irq_rerequest: cover property (@(posedge sys_clk) disable iff (!rst_b)
    rerequest ##1 status_irq);
  c_set_clear: cover property (@(posedge sys_clk) disable iff (!rst_b)
    |(flag_event & flag_clear));

endmodule : safety_guard_control
`default_nettype wire

// ===== rtl/safety_guard_pkg.sv
// constants shared by the safety guard block
package safety_guard_pkg;
  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'hF050;
  localparam logic [15:0] IDX_IRQ_FLAGS = 16'hF052;
  localparam logic [15:0] IDX_IRQ_CLEAR_LOW = 16'hF054;
  localparam logic [15:0] IDX_IRQ_CLEAR_HIGH = 16'hF055;
  localparam logic [15:0] IDX_RAM_GUARD = 16'hF0B0;
  localparam logic [15:0] IDX_GUARD0_LOW = 16'hF0B4;
  localparam logic [15:0] IDX_GUARD0_HIGH = 16'hF0B5;
  localparam logic [15:0] IDX_GUARD1_LOW = 16'hF0B6;
  localparam logic [15:0] IDX_GUARD1_HIGH = 16'hF0B7;
  localparam logic [15:0] IDX_PARITY_SET = 16'hF0BC;
  localparam logic [15:0] IDX_LOOP_LOW = 16'hF0BE;
  localparam logic [15:0] IDX_LOOP_HIGH = 16'hF0BF;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_AREA = 3'h0;
  // field layout
  localparam int AREA_W = 3;
  localparam int GUARD0_W = 6;
  localparam int GUARD1_W = 3;
  localparam int GROUPS = 9;
  localparam int LOOP_W = 2;
  localparam int FLAG_W = 3;
  localparam int BIT_PARITY = 0;
  localparam int BIT_CRC = 1;
  localparam int BIT_FLASH = 2;
  localparam int BIT_PARITY_ERROR_FLAG = 7;
  localparam int BIT_PARITY_RESET_ENABLE = 0;
  localparam int BIT_REREQ = 7;
  // enable bits that exist (bit 1 reserved)
  localparam logic [2:0] EN_MASK = 3'h5;
  // ram area selections
  localparam logic [2:0] AREA_OFF = 3'h0;
  localparam logic [2:0] AREA_64 = 3'h1;
  localparam logic [2:0] AREA_128 = 3'h2;
  localparam logic [2:0] AREA_256 = 3'h3;
  localparam logic [19:0] RAM_BASE_64 = 20'h0_EFC0;
  localparam logic [19:0] RAM_BASE_128 = 20'h0_EF80;
  localparam logic [19:0] RAM_BASE_256 = 20'h0_EF00;
  localparam logic [19:0] RAM_BASE_512 = 20'h0_EE00;
  localparam logic [19:0] RAM_TOP = 20'h0_EFFF;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_type;
endpackage : safety_guard_pkg

// ===== sim/cpu_write_model.sv
// cpu write path model: issues ram and register write strobes
`timescale 1ns/1ps
`default_nettype none
module cpu_write_model (
  input wire logic sys_clk, // system clock
  input wire logic ram_wr_en, // ram write granted
  input wire logic sfr_wr_en, // register write granted
  output logic ram_wr_req, // ram write strobe
  output logic [19:0] ram_wr_addr, // ram write address
  output logic sfr_wr_req, // register write strobe
  output logic [3:0] sfr_wr_group // register group
);
  initial begin
    ram_wr_req = 1'b0;
    ram_wr_addr = 20'h0_0000;
    sfr_wr_req = 1'b0;
    sfr_wr_group = 4'h0;
  end
  // one strobe per write; the address is turned over afterwards so a
  // stale value can never pass for a held one
  task automatic ram_write(input logic [19:0] a, output logic ok);
    @(posedge sys_clk);
    ram_wr_req <= 1'b1;
    ram_wr_addr <= a;
    @(posedge sys_clk);
    ram_wr_req <= 1'b0;
    ram_wr_addr <= ~a;
    @(posedge sys_clk);
    ok = ram_wr_en;
  endtask : ram_write
  task automatic sfr_write(input logic [3:0] g, output logic ok);
    @(posedge sys_clk);
    sfr_wr_req <= 1'b1;
    sfr_wr_group <= g;
    @(posedge sys_clk);
    sfr_wr_req <= 1'b0;
    sfr_wr_group <= ~g;
    @(posedge sys_clk);
    ok = sfr_wr_en;
  endtask : sfr_write
endmodule : cpu_write_model
`default_nettype wire

// ===== sim/safety_guard_control_test.sv
// self-checking bench for the safety guard block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, g) begin check_count++; if ((g) !== (x)) begin errors++; $display("unexpected %s exp %h got %h", nm, x, g); end end
module safety_guard_control_test;
  logic sys_clk, rst_b, read, write, waitrequest, ram_wr_req, ram_wr_en;
  logic sfr_wr_req, sfr_wr_en, ram_parity_err, crc_done, flash_done;
  logic unused_exec, unused_rst_opt, debug_mode, safety_reset, debug_break;
  logic parity_rst_status, unused_rst_status, status_irq, ok;
  logic [15:0] address;
  logic [31:0] writedata, readdata, q;
  logic [19:0] ram_wr_addr, ram_wr_addr_out, base;
  logic [3:0] sfr_wr_group;
  logic [1:0] uart_loopback;
  int errors, check_count, cycles;
  int n[5];
  int s[5];
  logic [15:0] ra[13] = '{16'hF050, 16'hF052, 16'hF054, 16'hF055,
    16'hF0BC, 16'hF0BE, 16'hF0BF, 16'hF0B0, 16'hF0B4, 16'hF0B5,
    16'hF0B6, 16'hF0B7, 16'hF0B1};
  logic [7:0] rx[13] = '{8'h05, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03,
    8'h00, 8'h07, 8'h3F, 8'h00, 8'h07, 8'h00, 8'h00};
  logic [19:0] ta[10] = '{20'h0_EDFF, 20'h0_EE00, 20'h0_EEFF, 20'h0_EF00,
    20'h0_EF7F, 20'h0_EF80, 20'h0_EFBF, 20'h0_EFC0, 20'h0_EFFF, 20'h0_F000};
  safety_guard_control safety_guard_control_i (.sys_clk, .rst_b, .address,
    .read, .write, .writedata, .readdata, .waitrequest, .ram_wr_req,
    .ram_wr_addr, .ram_wr_en, .ram_wr_addr_out, .sfr_wr_req, .sfr_wr_group,
    .sfr_wr_en, .ram_parity_err, .crc_done, .flash_done, .unused_exec,
    .unused_rst_opt, .debug_mode, .safety_reset, .parity_rst_status,
    .unused_rst_status, .debug_break, .status_irq, .uart_loopback);
  cpu_write_model cpu_write_model_i (.sys_clk, .ram_wr_en, .sfr_wr_en,
    .ram_wr_req, .ram_wr_addr, .sfr_wr_req, .sfr_wr_group);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // pulse counters: n[4] irq, n[3] reset, n[2] parity cause,
  // n[1] unused cause, n[0] break
  always @(posedge sys_clk) begin
    cycles++;
    if (status_irq === 1'b1) n[4]++;
    if (safety_reset === 1'b1) n[3]++;
    if (parity_rst_status === 1'b1) n[2]++;
    if (unused_rst_status === 1'b1) n[1]++;
    if (debug_break === 1'b1) n[0]++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= w;
    read <= !w;
    @(posedge sys_clk);
    while (waitrequest !== 1'b0 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 50) errors++;
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  task automatic mark();
    s = n;
  endtask : mark
  task automatic settle(input logic [4:0] x);
    logic [4:0] d;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) d[i] = (n[i] != s[i]);
    `CHK("pulses", x, d)
  endtask : settle
  task automatic pulse(input logic [3:0] e, input logic [4:0] x);
    mark();
    @(posedge sys_clk);
    {unused_exec, flash_done, crc_done, ram_parity_err} <= e;
    @(posedge sys_clk);
    {unused_exec, flash_done, crc_done, ram_parity_err} <= 4'h0;
    settle(x);
  endtask : pulse
  task automatic check_resets();
    for (int i = 0; i < 13; i++) begin
      bus(1'b0, ra[i], 8'h00);
      `CHK("reset value", 32'h0000_0000, q)
    end
    `CHK("loopback", 2'b00, uart_loopback)
  endtask : check_resets
  initial begin
    {rst_b, read, write, ram_parity_err, crc_done, flash_done} = 6'h00;
    {unused_exec, unused_rst_opt, debug_mode} = 3'h0;
    address = 16'h0000;
    writedata = 32'h0000_0000;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    check_resets();
    // ----------------------------------------
    // register access kinds
    // ----------------------------------------
    for (int i = 0; i < 13; i++) begin
      bus(1'b1, ra[i], 8'hFF);
      bus(1'b0, ra[i], 8'h00);
      `CHK("readback", {24'h00_0000, rx[i]}, q)
    end
    `CHK("loopback", 2'b11, uart_loopback)
    // reverse order: the guards must fall before the parity setting
    for (int i = 12; i >= 0; i--) bus(1'b1, ra[i], 8'h00);
    $display("register access test done");
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 16'hF0B0, c[7:0]);
      base = c == 1 ? 20'h0_EFC0 : c == 2 ? 20'h0_EF80 :
             c == 3 ? 20'h0_EF00 : 20'h0_EE00;
      for (int j = 0; j < 10; j++) begin
        cpu_write_model_i.ram_write(ta[j], ok);
        `CHK("ram_wr_en", c == 0 || ta[j] < base || ta[j] > 20'h0_EFFF, ok)
        `CHK("ram_wr_addr_out", ta[j], ram_wr_addr_out)
      end
    end
    bus(1'b1, 16'hF0B0, 8'h00);
    bus(1'b0, 16'hF052, 8'h00);
    `CHK("flags after guard", 32'h0000_0000, q)
    $display("ram guard test done");
    bus(1'b1, 16'hF0B4, 8'h15);
    bus(1'b1, 16'hF0B6, 8'h02);
    for (int g = 0; g < 10; g++) begin
      cpu_write_model_i.sfr_write(g[3:0], ok);
      `CHK("sfr_wr_en", ~(g < 8 && 8'h95 >> g & 1), ok)
    end
    bus(1'b0, 16'hF0B4, 8'h00);
    `CHK("guard0 read", 32'h0000_0015, q)
    bus(1'b1, 16'hF0B4, 8'h00);
    bus(1'b1, 16'hF0B6, 8'h00);
    $display("register guard test done");
    bus(1'b1, 16'hF050, 8'h05);
    bus(1'b1, 16'hF0BC, 8'h01);
    unused_rst_opt <= 1'b1;
    pulse(4'h1, 5'b11100);
    bus(1'b0, 16'hF052, 8'h00);
    `CHK("flags", 32'h0000_0001, q)
    bus(1'b0, 16'hF0BC, 8'h00);
    `CHK("parity setting", 32'h0000_0081, q)
    pulse(4'h1, 5'b01100);
    mark();
    bus(1'b1, 16'hF055, 8'h80);
    settle(5'b10000);
    mark();
    bus(1'b1, 16'hF055, 8'h00);
    settle(5'b00000);
    bus(1'b1, 16'hF054, 8'h01);
    bus(1'b0, 16'hF052, 8'h00);
    `CHK("flags cleared", 32'h0000_0000, q)
    bus(1'b1, 16'hF0BC, 8'h81);
    bus(1'b0, 16'hF0BC, 8'h00);
    `CHK("parity flag cleared", 32'h0000_0001, q)
    debug_mode <= 1'b1;
    pulse(4'h1, 5'b10001);
    pulse(4'h8, 5'b00000);
    debug_mode <= 1'b0;
    pulse(4'h8, 5'b01010);
    unused_rst_opt <= 1'b0;
    pulse(4'h8, 5'b00000);
    bus(1'b1, 16'hF054, 8'h05);
    pulse(4'h4, 5'b10000);
    pulse(4'h2, 5'b00000);
    bus(1'b0, 16'hF052, 8'h00);
    `CHK("flags flash", 32'h0000_0004, q)
    $display("status event test done");
    bus(1'b1, 16'hF0BE, 8'h03);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    check_resets();
    $display("mid-run reset test done");
    test_done();
  end
endmodule : safety_guard_control_test
`default_nettype wire
